// file: core/vxw_map.svh
// vxw_map.svh: offsets, field positions, reset values for the extension
// write-protect and timing register bank.
// assumes an indexed port pair: index register plus data port, 8-bit data.
//
// Behaviour
// RULE1: protect bit 7 blocks legacy adapter mode, config, colour-select writes.
// RULE2: protect bit 6 blocks light-pen clear/set and feature-control bits 1:0.
// RULE3: protect bit 5 blocks legacy display-timing registers.
// RULE4: protect bit 4 blocks legacy monitor-timing registers.
// RULE5: protect bit 3 blocks graphics, sequencer, attribute, feature, misc bits 0-1,4-5.
// RULE6: protect bit 2 blocks shared crt registers C through F.
// RULE7: protect bit 1 blocks crt display-timing registers, overflow bits 1 and 4.
// RULE8: protect bit 0 blocks crt monitor timing, overflow 0,2,3, misc 2-3,6-7.
// RULE9: timing write needs active-state enable and clear protect bit; code skips the enable check for misc bits 2-3,6-7.
// RULE10: timing bits 7/6 invert legacy vertical/horizontal retrace polarity.
// RULE11: default polarity colour v+h high, mono v low h high.
// RULE12: timing bit 5 clear forces video on in colour text mode.
// RULE13: timing bit 4 doubles scan lines and legacy vertical values.
// RULE14: timing bit 3 forces legacy interleave 1:4/3:2, else 1:1/2:1.
// RULE15: first revision bit 3 also forces sync tweaks, interleave from bandwidth; code holds legacy interleave at VXW_IL_SEQ.
// RULE16: width 000 nine dots, 001 eight, 010 six, others reserved.
// RULE17: width bit 0 is one storage bit shared with sequencer reg 1 bit 0.
// RULE18: width bit 1 cleared by sequencer reg 1 write and resets.
// RULE19: software should write width bit 2 as zero.
// RULE20: software picks interleave per dot clock in nine-dot mode.
// RULE21: bandwidth bits 5-4 legacy, 2-0 standard, reset zero, others reserved.
// RULE22: standard bandwidth field decodes to interleave selection.
// RULE23: all protect bits read/write, reset to zero.
// RULE24: blocked writes silently dropped, reads still return stored values.
// RULE25: partly protected registers update only their unprotected bits.
`ifndef VXW_MAP_SVH
`define VXW_MAP_SVH
`define VXW_IDX_WRITE_PROTECT 8'h84
`define VXW_IDX_TIMING_CTL    8'h85
`define VXW_IDX_BANDWIDTH_CTL 8'h86
`define VXW_BW_WRITE_MASK     8'h37
`define VXW_TIMING_RESET      8'h00
`define VXW_BW_RESET          8'h00
`define VXW_WP_RESET          8'h00
`define VXW_WP_LEG_MODE       7
`define VXW_WP_LPEN           6
`define VXW_WP_LEG_DISP       5
`define VXW_WP_LEG_MON        4
`define VXW_WP_STD_OTHER      3
`define VXW_WP_SHARED         2
`define VXW_WP_CRT_DISP       1
`define VXW_WP_CRT_MON        0
`define VXW_OVF_DISP_MASK     8'h12
`define VXW_OVF_MON_MASK      8'h0D
`define VXW_MISC_STD_MASK     8'h33
`define VXW_MISC_MON_MASK     8'hCC
`define VXW_FEATURE_PEN_MASK  8'h03
`endif

// file: core/vxw_pkg.sv
// vxw_pkg.sv: types for the extension register bank.
// assumes vxw_map.svh supplies the numeric constants.
package vxw_pkg;
  // target register groups that the host is trying to write
  typedef enum logic [3:0] {
    VXW_TGT_NONE,
    VXW_TGT_LEG_MODE,
    VXW_TGT_LPEN,
    VXW_TGT_FEATURE,
    VXW_TGT_LEG_DISP,
    VXW_TGT_LEG_MON,
    VXW_TGT_STD_OTHER,
    VXW_TGT_SHARED,
    VXW_TGT_CRT_DISP,
    VXW_TGT_CRT_MON,
    VXW_TGT_OVERFLOW,
    VXW_TGT_MISC
  } vxw_target_type;

  typedef enum logic [2:0] {
    VXW_IL_SEQ,
    VXW_IL_1_1,
    VXW_IL_1_2,
    VXW_IL_1_7,
    VXW_IL_1_4,
    VXW_IL_3_2,
    VXW_IL_2_1,
    VXW_IL_RSVD
  } vxw_interleave_type;

  typedef struct packed {
    logic       vsync_invert;
    logic       hsync_invert;
    logic       video_forced_on;
    logic       scan_double;
    logic       sync_tweak;
    logic [1:0] cell_dots_sel;
  } vxw_mode_type;
endpackage : vxw_pkg

// file: core/vxw_ext_regs.sv
// vxw_ext_regs.sv: write-protect, timing-control and bandwidth registers
// with the write gate for the protected register groups outside.
// assumes the host decodes an indexed data-port cycle into a one-cycle
// write or read strobe, and the protected registers apply the gate masks.
`timescale 1ns/100ps
`include "vxw_map.svh"
module vxw_ext_regs #(
  parameter logic FIRST_REV = 1'b0
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   sync_reset_i,
  input  wire logic [7:0]             ext_index_i,
  input  wire logic                   ext_wr_i,
  input  wire logic [7:0]             ext_wdata_i,
  output logic [7:0]                  ext_rdata_o,
  input  wire logic                   seq_clk_wr_i,
  input  wire logic [7:0]             seq_clk_wdata_i,
  output logic                        seq_clk_bit0_o,
  input  wire vxw_pkg::vxw_target_type tgt_i,
  input  wire logic                   tgt_wr_i,
  input  wire logic                   ext_active_en_i,
  output logic [7:0]                  tgt_write_mask_o,
  input  wire logic                   legacy_mono_i,
  input  wire logic                   legacy_color_text_i,
  input  wire logic                   legacy_video_en_i,
  input  wire logic                   vretrace_raw_i,
  input  wire logic                   hretrace_raw_i,
  output logic                        vertical_retrace_o,
  output logic                        horizontal_retrace_o,
  output logic                        video_on_o,
  output vxw_pkg::vxw_mode_type       mode_o,
  output vxw_pkg::vxw_interleave_type std_interleave_o,
  output vxw_pkg::vxw_interleave_type leg_interleave_o,
  output logic [1:0]                  leg_bandwidth_o
);
  logic [7:0] write_protect_reg, write_protect_next;
  logic [7:0] timing_ctl_reg, timing_ctl_next;
  logic [7:0] bandwidth_ctl_reg, bandwidth_ctl_next;

  // every check below runs on the register clock, quiet in reset
  default clocking chk_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  always_comb begin
    write_protect_next = write_protect_reg;
    timing_ctl_next    = timing_ctl_reg;
    bandwidth_ctl_next = bandwidth_ctl_reg;
    if (ext_wr_i) begin
      case (ext_index_i)
        // RULE23: protect register plain read/write
        `VXW_IDX_WRITE_PROTECT: write_protect_next = ext_wdata_i;
        // RULE19: bit 2 stored, forces the reserved cell width when set
        `VXW_IDX_TIMING_CTL:    timing_ctl_next = ext_wdata_i;
        // RULE21: reserved bandwidth bits stay zero
        `VXW_IDX_BANDWIDTH_CTL: bandwidth_ctl_next = ext_wdata_i & `VXW_BW_WRITE_MASK;
        default: ;
      endcase
    end
    // RULE17: width bit 0 shared with sequencer clocking bit 0
    // RULE18: sequencer write clears width bit 1
    if (seq_clk_wr_i) begin
      timing_ctl_next[0] = seq_clk_wdata_i[0];
      timing_ctl_next[1] = 1'b0;
    end
    // RULE18: sync reset clears width bit 1
    // RULE21: sync reset clears bandwidth fields
    if (sync_reset_i) begin
      timing_ctl_next[1] = 1'b0;
      bandwidth_ctl_next = `VXW_BW_RESET;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_protect_reg <= `VXW_WP_RESET;
      timing_ctl_reg    <= `VXW_TIMING_RESET;
      bandwidth_ctl_reg <= `VXW_BW_RESET;
    end else begin
      write_protect_reg <= write_protect_next;
      timing_ctl_reg    <= timing_ctl_next;
      bandwidth_ctl_reg <= bandwidth_ctl_next;
    end
  end

  always_comb begin
    case (ext_index_i)
      `VXW_IDX_WRITE_PROTECT: ext_rdata_o = write_protect_reg;
      `VXW_IDX_TIMING_CTL:    ext_rdata_o = timing_ctl_reg;
      `VXW_IDX_BANDWIDTH_CTL: ext_rdata_o = bandwidth_ctl_reg;
      default:                ext_rdata_o = 8'h00;
    endcase
  end
  assign seq_clk_bit0_o = timing_ctl_reg[0];

  // --------------------------------------------------------------
  // write gate for protected groups
  // --------------------------------------------------------------
  function automatic logic [7:0] gate_mask(input vxw_pkg::vxw_target_type t,
                                          input logic [7:0] wp,
                                          input logic act);
    logic [7:0] m;
    m = 8'h00;
    case (t)
      // RULE1: legacy adapter registers
      vxw_pkg::VXW_TGT_LEG_MODE:  m = wp[`VXW_WP_LEG_MODE] ? 8'h00 : 8'hFF;
      // RULE2: light pen latches
      vxw_pkg::VXW_TGT_LPEN:      m = wp[`VXW_WP_LPEN] ? 8'h00 : 8'hFF;
      // RULE2: feature bits 1:0, RULE5: rest of feature control
      vxw_pkg::VXW_TGT_FEATURE:
        m = (wp[`VXW_WP_LPEN] ? 8'h00 : `VXW_FEATURE_PEN_MASK)
          | (wp[`VXW_WP_STD_OTHER] ? 8'h00 : ~`VXW_FEATURE_PEN_MASK);
      // RULE3: RULE9: legacy display timing with active enable
      vxw_pkg::VXW_TGT_LEG_DISP:  m = (act && !wp[`VXW_WP_LEG_DISP]) ? 8'hFF : 8'h00;
      // RULE4: RULE9: legacy monitor timing
      vxw_pkg::VXW_TGT_LEG_MON:   m = (act && !wp[`VXW_WP_LEG_MON]) ? 8'hFF : 8'h00;
      // RULE5: graphics, sequencer, attribute groups
      vxw_pkg::VXW_TGT_STD_OTHER: m = wp[`VXW_WP_STD_OTHER] ? 8'h00 : 8'hFF;
      // RULE6: RULE9: shared crt registers
      vxw_pkg::VXW_TGT_SHARED:    m = (act && !wp[`VXW_WP_SHARED]) ? 8'hFF : 8'h00;
      // RULE7: RULE9: crt display timing
      vxw_pkg::VXW_TGT_CRT_DISP:  m = (act && !wp[`VXW_WP_CRT_DISP]) ? 8'hFF : 8'h00;
      // RULE8: RULE9: crt monitor timing
      vxw_pkg::VXW_TGT_CRT_MON:   m = (act && !wp[`VXW_WP_CRT_MON]) ? 8'hFF : 8'h00;
      // RULE25: overflow split between display and monitor groups
      vxw_pkg::VXW_TGT_OVERFLOW:
        m = act ? ((wp[`VXW_WP_CRT_DISP] ? 8'h00 : `VXW_OVF_DISP_MASK)
                 | (wp[`VXW_WP_CRT_MON] ? 8'h00 : `VXW_OVF_MON_MASK)) : 8'h00;
      // RULE25: misc output split between groups
      vxw_pkg::VXW_TGT_MISC:
        m = (wp[`VXW_WP_STD_OTHER] ? 8'h00 : `VXW_MISC_STD_MASK)
          | (wp[`VXW_WP_CRT_MON] ? 8'h00 : `VXW_MISC_MON_MASK);
      default: m = 8'h00;
    endcase
    return m;
  endfunction : gate_mask

  // RULE24: masked bits simply keep their stored value, no error
  assign tgt_write_mask_o = tgt_wr_i ? gate_mask(tgt_i, write_protect_reg, ext_active_en_i)
                                     : 8'h00;

  // --------------------------------------------------------------
  // mode outputs
  // --------------------------------------------------------------
  function automatic vxw_pkg::vxw_interleave_type std_il(input logic [2:0] f);
    case (f)
      3'h0:    return vxw_pkg::VXW_IL_SEQ;
      3'h1:    return vxw_pkg::VXW_IL_1_1;
      3'h2:    return vxw_pkg::VXW_IL_1_2;
      3'h3:    return vxw_pkg::VXW_IL_1_7;
      3'h4:    return vxw_pkg::VXW_IL_1_4;
      3'h5:    return vxw_pkg::VXW_IL_3_2;
      default: return vxw_pkg::VXW_IL_RSVD;
    endcase
  endfunction : std_il

  always_comb begin
    // RULE22: standard-mode interleave decode
    std_interleave_o = std_il(bandwidth_ctl_reg[2:0]);
    leg_bandwidth_o  = bandwidth_ctl_reg[5:4];
    // RULE14: legacy interleave forced by bit 3
    // RULE15: first revision holds it at VXW_IL_SEQ instead of taking it from the bandwidth field
    if (FIRST_REV)
      leg_interleave_o = vxw_pkg::VXW_IL_SEQ;
    else if (timing_ctl_reg[3])
      leg_interleave_o = timing_ctl_reg[0] ? vxw_pkg::VXW_IL_1_4 : vxw_pkg::VXW_IL_3_2;
    else
      leg_interleave_o = timing_ctl_reg[0] ? vxw_pkg::VXW_IL_1_1 : vxw_pkg::VXW_IL_2_1;
    mode_o.vsync_invert    = timing_ctl_reg[7];
    mode_o.hsync_invert    = timing_ctl_reg[6];
    // RULE12: video forced on unless bit 5 allows disable
    mode_o.video_forced_on = !timing_ctl_reg[5];
    // RULE13: scan doubling flag for the legacy timing logic
    mode_o.scan_double     = timing_ctl_reg[4];
    // RULE15: sync width and position tweak only on first revision
    mode_o.sync_tweak      = FIRST_REV & timing_ctl_reg[3];
    // RULE16: 0 nine, 1 eight, 2 six, 3 reserved
    mode_o.cell_dots_sel   = timing_ctl_reg[2] ? 2'h3 : timing_ctl_reg[1:0];
  end

  // RULE10: RULE11: colour default high, mono vertical low
  assign vertical_retrace_o   = vretrace_raw_i ^ legacy_mono_i ^ timing_ctl_reg[7];
  assign horizontal_retrace_o = hretrace_raw_i ^ timing_ctl_reg[6];
  // RULE12: enable bit ignored in colour text when bit 5 clear
  assign video_on_o = (legacy_color_text_i && !timing_ctl_reg[5]) ? 1'b1 : legacy_video_en_i;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  // RULE1: legacy adapter group blocked
  chk_legacy_block: assert property ( // RULE1
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_LEG_MODE && write_protect_reg[7])
      |-> tgt_write_mask_o == 8'h00) else $error("legacy mode write not blocked");
  // RULE2: light pen group blocked
  chk_lpen_block: assert property ( // RULE2
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_LPEN && write_protect_reg[6])
      |-> tgt_write_mask_o == 8'h00) else $error("light pen write not blocked");
  // RULE2: feature low bits gated apart
  chk_feature_split: assert property ( // RULE2
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_FEATURE && write_protect_reg[6]
     && !write_protect_reg[3]) |-> tgt_write_mask_o == ~`VXW_FEATURE_PEN_MASK)
    else $error("feature partial mask wrong");
  // RULE3: legacy display group blocked
  chk_leg_disp_block: assert property ( // RULE3
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_LEG_DISP && write_protect_reg[5])
      |-> tgt_write_mask_o == 8'h00) else $error("legacy display write not blocked");
  // RULE4: legacy monitor group blocked
  chk_leg_mon_block: assert property ( // RULE4
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_LEG_MON && write_protect_reg[4])
      |-> tgt_write_mask_o == 8'h00) else $error("legacy monitor write not blocked");
  // RULE5: standard group blocked
  chk_std_block: assert property ( // RULE5
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_STD_OTHER && write_protect_reg[3])
      |-> tgt_write_mask_o == 8'h00) else $error("standard group write not blocked");
  // RULE6: shared crt group blocked
  chk_shared_block: assert property ( // RULE6
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_SHARED && write_protect_reg[2])
      |-> tgt_write_mask_o == 8'h00) else $error("shared crt write not blocked");
  // RULE7: crt display group blocked
  chk_crt_disp_block: assert property ( // RULE7
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_CRT_DISP && write_protect_reg[1])
      |-> tgt_write_mask_o == 8'h00) else $error("crt display write not blocked");
  // RULE8: crt monitor group blocked
  chk_wp_blocks_crt: assert property ( // RULE8
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_CRT_MON && write_protect_reg[0])
      |-> tgt_write_mask_o == 8'h00) else $error("crt monitor write not blocked");
  // RULE9: no enable, no legacy display timing write
  chk_active_gate: assert property ( // RULE9
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_LEG_DISP && !ext_active_en_i)
      |-> tgt_write_mask_o == 8'h00) else $error("write passed without enable");
  // RULE9: enabled open group passes
  chk_active_open: assert property ( // RULE9
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_CRT_MON && ext_active_en_i
     && !write_protect_reg[0]) |-> tgt_write_mask_o == 8'hFF)
    else $error("enabled timing write blocked");
  // RULE24: no attempt, no mask
  chk_idle_mask: assert property ( // RULE24
    !tgt_wr_i |-> tgt_write_mask_o == 8'h00) else $error("mask without write attempt");
  // RULE25: overflow split by group
  chk_ovf_split: assert property ( // RULE25
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_OVERFLOW && ext_active_en_i
     && write_protect_reg[1] && !write_protect_reg[0])
      |-> tgt_write_mask_o == `VXW_OVF_MON_MASK) else $error("overflow mask wrong");
  // RULE25: misc split by group
  chk_misc_split: assert property ( // RULE25
    (tgt_wr_i && tgt_i == vxw_pkg::VXW_TGT_MISC && write_protect_reg[0]
     && !write_protect_reg[3]) |-> tgt_write_mask_o == `VXW_MISC_STD_MASK)
    else $error("misc partial mask wrong");

  // RULE17: shared bit follows sequencer
  chk_shared_bit0: assert property ( // RULE17
    seq_clk_wr_i |=> seq_clk_bit0_o == $past(seq_clk_wdata_i[0]))
    else $error("shared width bit lost");
  // RULE18: sequencer write clears bit 1
  chk_seq_clears_w1: assert property ( // RULE18
    seq_clk_wr_i |=> !timing_ctl_reg[1]) else $error("width bit 1 not cleared");
  // RULE18: sync reset clears bit 1
  chk_sync_clears_w1: assert property ( // RULE18
    sync_reset_i |=> !timing_ctl_reg[1]) else $error("width bit 1 kept over sync reset");
  // RULE21: reserved bandwidth bits zero
  chk_bw_reserved: assert property ( // RULE21
    (bandwidth_ctl_reg & ~`VXW_BW_WRITE_MASK) == 8'h00)
    else $error("reserved bandwidth bits set");
  // RULE21: sync reset clears bandwidth
  chk_sync_clears_bw: assert property ( // RULE21
    sync_reset_i |=> bandwidth_ctl_reg == `VXW_BW_RESET)
    else $error("bandwidth kept over sync reset");
  // RULE21: bandwidth write lands
  chk_bw_write: assert property ( // RULE21
    (ext_wr_i && ext_index_i == `VXW_IDX_BANDWIDTH_CTL && !sync_reset_i)
      |=> bandwidth_ctl_reg == ($past(ext_wdata_i) & `VXW_BW_WRITE_MASK))
    else $error("bandwidth write lost");
  // RULE23: protect write lands
  chk_wp_write: assert property ( // RULE23
    (ext_wr_i && ext_index_i == `VXW_IDX_WRITE_PROTECT)
      |=> write_protect_reg == $past(ext_wdata_i)) else $error("protect write lost");
  // RULE24: protect holds without a write
  chk_wp_hold: assert property ( // RULE24
    !(ext_wr_i && ext_index_i == `VXW_IDX_WRITE_PROTECT) |=> $stable(write_protect_reg))
    else $error("protect register moved without a write");

  // RULE10: inverted colour vertical retrace
  chk_vret_invert: assert property ( // RULE10
    (timing_ctl_reg[7] && !legacy_mono_i) |-> vertical_retrace_o == !vretrace_raw_i)
    else $error("vertical retrace not inverted");
  // RULE11: default mono vertical low
  chk_vret_mono: assert property ( // RULE11
    (!timing_ctl_reg[7] && legacy_mono_i) |-> vertical_retrace_o == !vretrace_raw_i)
    else $error("mono vertical retrace polarity wrong");
  // RULE11: default horizontal high
  chk_hret_default: assert property ( // RULE11
    !timing_ctl_reg[6] |-> horizontal_retrace_o == hretrace_raw_i)
    else $error("horizontal retrace polarity wrong");
  // RULE12: video forced in colour text
  chk_video_forced: assert property ( // RULE12
    (legacy_color_text_i && !timing_ctl_reg[5]) |-> video_on_o)
    else $error("video not forced on");
  // RULE12: enable bit obeyed when allowed
  chk_video_normal: assert property ( // RULE12
    timing_ctl_reg[5] |-> video_on_o == legacy_video_en_i)
    else $error("video enable not obeyed");
  // RULE14: forced legacy interleave pair
  chk_leg_forced: assert property ( // RULE14
    (!FIRST_REV && timing_ctl_reg[3]) |-> (leg_interleave_o == vxw_pkg::VXW_IL_1_4
      || leg_interleave_o == vxw_pkg::VXW_IL_3_2)) else $error("legacy interleave not forced");
  // RULE16: reserved widths reported
  chk_width_rsvd: assert property ( // RULE16
    (timing_ctl_reg[2] || timing_ctl_reg[1:0] == 2'h3) |-> mode_o.cell_dots_sel == 2'h3)
    else $error("reserved width not flagged");
  // RULE22: reserved bandwidth codes
  chk_std_il_rsvd: assert property ( // RULE22
    bandwidth_ctl_reg[2:1] == 2'h3 |-> std_interleave_o == vxw_pkg::VXW_IL_RSVD)
    else $error("reserved interleave code decoded");
endmodule : vxw_ext_regs

// file: test/vxw_tb.sv
// vxw_tb.sv: self-checking bench for the extension register bank.
// assumes vxw_map.svh offsets and the default first-revision parameter.
`timescale 1ns/100ps
`include "vxw_map.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic                        clk_sys_i = 1'b0;
  logic                        reset_n_i = 1'b0;
  logic                        sync_rst  = 1'b0;
  logic [7:0]                  ext_index = 8'h00;
  logic                        ext_wr    = 1'b0;
  logic [7:0]                  ext_wdata = 8'h00;
  logic [7:0]                  ext_rdata;
  logic                        seq_wr    = 1'b0;
  logic [7:0]                  seq_wdata = 8'h00;
  logic                        seq_bit0;
  vxw_pkg::vxw_target_type     tgt       = vxw_pkg::VXW_TGT_NONE;
  logic                        tgt_wr    = 1'b0;
  logic                        act_en    = 1'b0;
  logic [7:0]                  wmask;
  logic                        mono = 1'b0, ctext = 1'b0, vid_en = 1'b0;
  logic                        vraw = 1'b1, hraw = 1'b1, vret, hret, video_on;
  vxw_pkg::vxw_mode_type       mode;
  vxw_pkg::vxw_interleave_type std_il, leg_il;
  logic [1:0]                  leg_bw;
  int                          fails = 0, check_count = 0, cycles = 0;

  vxw_ext_regs uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sync_reset_i(sync_rst),
    .ext_index_i(ext_index), .ext_wr_i(ext_wr), .ext_wdata_i(ext_wdata),
    .ext_rdata_o(ext_rdata), .seq_clk_wr_i(seq_wr), .seq_clk_wdata_i(seq_wdata),
    .seq_clk_bit0_o(seq_bit0), .tgt_i(tgt), .tgt_wr_i(tgt_wr), .ext_active_en_i(act_en),
    .tgt_write_mask_o(wmask), .legacy_mono_i(mono), .legacy_color_text_i(ctext),
    .legacy_video_en_i(vid_en), .vretrace_raw_i(vraw), .hretrace_raw_i(hraw),
    .vertical_retrace_o(vret), .horizontal_retrace_o(hret), .video_on_o(video_on),
    .mode_o(mode), .std_interleave_o(std_il), .leg_interleave_o(leg_il),
    .leg_bandwidth_o(leg_bw));

  always #12.5 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  // wr and seq end on a falling edge, rd, m and r 1 ns after it, so a following call waits about a full cycle
  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk_sys_i); ext_index = idx; ext_wdata = d; ext_wr = 1'b1;
    @(negedge clk_sys_i); ext_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    @(negedge clk_sys_i); ext_index = idx;
    #1 `CHK(nm, exp, ext_rdata)
  endtask : rd
  task seq(input logic [7:0] d);
    @(negedge clk_sys_i); seq_wdata = d; seq_wr = 1'b1;
    @(negedge clk_sys_i); seq_wr = 1'b0;
  endtask : seq
  task m(input vxw_pkg::vxw_target_type t, input logic [7:0] wp, input logic a,
         input logic [7:0] exp);
    wr(`VXW_IDX_WRITE_PROTECT, wp); tgt = t; tgt_wr = 1'b1; act_en = a;
    #1 `CHK("write mask", exp, wmask)
  endtask : m
  task grp(input vxw_pkg::vxw_target_type t, input int b);
    m(t, 8'h01 << b, 1'b1, 8'h00);
    m(t, ~(8'h01 << b), 1'b1, 8'hFF);
  endtask : grp
  task r(input logic [7:0] tc, input logic mn, input logic ev, input logic eh);
    wr(`VXW_IDX_TIMING_CTL, tc); mono = mn;
    #1 `CHK("vretrace", ev, vret)
    `CHK("hretrace", eh, hret)
  endtask : r

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    rd(`VXW_IDX_WRITE_PROTECT, 8'h00, "protect reset");
    rd(`VXW_IDX_TIMING_CTL, 8'h00, "timing reset");
    rd(`VXW_IDX_BANDWIDTH_CTL, 8'h00, "bandwidth reset");
    wr(`VXW_IDX_WRITE_PROTECT, 8'hA5);
    rd(`VXW_IDX_WRITE_PROTECT, 8'hA5, "protect rw");
    wr(`VXW_IDX_BANDWIDTH_CTL, 8'hFF);
    rd(`VXW_IDX_BANDWIDTH_CTL, 8'h37, "bandwidth reserved");
    `CHK("leg bandwidth", 2'b11, leg_bw)
    wr(8'h87, 8'hFF);
    rd(8'h87, 8'h00, "unmapped");
  endtask : t_regs
  task t_protect;
    grp(vxw_pkg::VXW_TGT_LEG_MODE, 7);
    grp(vxw_pkg::VXW_TGT_LPEN, 6);
    grp(vxw_pkg::VXW_TGT_LEG_DISP, 5);
    grp(vxw_pkg::VXW_TGT_LEG_MON, 4);
    grp(vxw_pkg::VXW_TGT_STD_OTHER, 3);
    grp(vxw_pkg::VXW_TGT_SHARED, 2);
    grp(vxw_pkg::VXW_TGT_CRT_DISP, 1);
    grp(vxw_pkg::VXW_TGT_CRT_MON, 0);
    m(vxw_pkg::VXW_TGT_OVERFLOW, 8'h02, 1'b1, 8'h0D);
    m(vxw_pkg::VXW_TGT_OVERFLOW, 8'h01, 1'b1, 8'h12);
    m(vxw_pkg::VXW_TGT_MISC, 8'h01, 1'b1, 8'h33);
    m(vxw_pkg::VXW_TGT_MISC, 8'h08, 1'b1, 8'hCC);
    m(vxw_pkg::VXW_TGT_FEATURE, 8'h40, 1'b1, 8'hFC);
    m(vxw_pkg::VXW_TGT_FEATURE, 8'h08, 1'b1, 8'h03);
    m(vxw_pkg::VXW_TGT_CRT_MON, 8'h00, 1'b0, 8'h00);
    tgt_wr = 1'b0;
    #1 `CHK("idle mask", 8'h00, wmask)
  endtask : t_protect
  task t_retrace;
    r(8'h00, 1'b0, 1'b1, 1'b1);
    r(8'h00, 1'b1, 1'b0, 1'b1);
    r(8'hC0, 1'b0, 1'b0, 1'b0);
    r(8'hC0, 1'b1, 1'b1, 1'b0);
    r(8'h40, 1'b0, 1'b1, 1'b0);
    vraw = 1'b0; hraw = 1'b0;
    r(8'h00, 1'b1, 1'b1, 1'b0);
  endtask : t_retrace
  task t_video;
    ctext = 1'b1; vid_en = 1'b0;
    wr(`VXW_IDX_TIMING_CTL, 8'h00);
    #1 `CHK("video forced", 1'b1, video_on)
    wr(`VXW_IDX_TIMING_CTL, 8'h20);
    #1 `CHK("video off", 1'b0, video_on)
    vid_en = 1'b1;
    #1 `CHK("video on", 1'b1, video_on)
  endtask : t_video
  task t_width;
    // timing writes keep bit 2 zero
    wr(`VXW_IDX_TIMING_CTL, 8'h10);
    `CHK("scan double", 1'b1, mode.scan_double)
    `CHK("video forced flag", 1'b1, mode.video_forced_on)
    wr(`VXW_IDX_TIMING_CTL, 8'hE8);
    `CHK("vsync invert", 1'b1, mode.vsync_invert)
    `CHK("hsync invert", 1'b1, mode.hsync_invert)
    `CHK("video allowed", 1'b0, mode.video_forced_on)
    `CHK("sync tweak", 1'b0, mode.sync_tweak)
    `CHK("nine dots", 2'd0, mode.cell_dots_sel)
    wr(`VXW_IDX_TIMING_CTL, 8'h01);
    `CHK("eight dots", 2'd1, mode.cell_dots_sel)
    `CHK("shared bit", 1'b1, seq_bit0)
    wr(`VXW_IDX_TIMING_CTL, 8'h02);
    `CHK("six dots", 2'd2, mode.cell_dots_sel)
    wr(`VXW_IDX_TIMING_CTL, 8'h03);
    `CHK("reserved width", 2'h3, mode.cell_dots_sel)
    seq(8'h02);
    rd(`VXW_IDX_TIMING_CTL, 8'h00, "seq write clears");
    seq(8'h01);
    rd(`VXW_IDX_TIMING_CTL, 8'h01, "seq write shares");
  endtask : t_width
  task t_sync;
    wr(`VXW_IDX_BANDWIDTH_CTL, 8'h37);
    wr(`VXW_IDX_TIMING_CTL, 8'h03);
    @(negedge clk_sys_i); sync_rst = 1'b1;
    @(negedge clk_sys_i); sync_rst = 1'b0;
    rd(`VXW_IDX_BANDWIDTH_CTL, 8'h00, "sync bandwidth");
    rd(`VXW_IDX_TIMING_CTL, 8'h01, "sync width bit1");
  endtask : t_sync
  task t_interleave;
    vxw_pkg::vxw_interleave_type il [6];
    il = '{vxw_pkg::VXW_IL_SEQ, vxw_pkg::VXW_IL_1_1, vxw_pkg::VXW_IL_1_2,
           vxw_pkg::VXW_IL_1_7, vxw_pkg::VXW_IL_1_4, vxw_pkg::VXW_IL_3_2};
    for (int i = 0; i < 6; i++) begin
      wr(`VXW_IDX_BANDWIDTH_CTL, 8'(i));
      `CHK("std interleave", il[i], std_il)
    end
    wr(`VXW_IDX_BANDWIDTH_CTL, 8'h06);
    `CHK("std reserved", vxw_pkg::VXW_IL_RSVD, std_il)
    wr(`VXW_IDX_TIMING_CTL, 8'h09);
    `CHK("leg 1:4", vxw_pkg::VXW_IL_1_4, leg_il)
    wr(`VXW_IDX_TIMING_CTL, 8'h08);
    `CHK("leg 3:2", vxw_pkg::VXW_IL_3_2, leg_il)
    wr(`VXW_IDX_TIMING_CTL, 8'h01);
    `CHK("leg 1:1", vxw_pkg::VXW_IL_1_1, leg_il)
    wr(`VXW_IDX_TIMING_CTL, 8'h00);
    `CHK("leg 2:1", vxw_pkg::VXW_IL_2_1, leg_il)
    // nine-dot cell paired with 1:4 interleave
    wr(`VXW_IDX_BANDWIDTH_CTL, 8'h04);
    `CHK("nine-dot 1:4", vxw_pkg::VXW_IL_1_4, std_il)
  endtask : t_interleave
  task t_reset;
    wr(`VXW_IDX_WRITE_PROTECT, 8'hFF);
    wr(`VXW_IDX_BANDWIDTH_CTL, 8'h37);
    wr(`VXW_IDX_TIMING_CTL, 8'hC3);
    @(negedge clk_sys_i); reset_n_i = 1'b0;
    @(negedge clk_sys_i); reset_n_i = 1'b1;
    rd(`VXW_IDX_WRITE_PROTECT, 8'h00, "protect after reset");
    rd(`VXW_IDX_BANDWIDTH_CTL, 8'h00, "bandwidth after reset");
    rd(`VXW_IDX_TIMING_CTL, 8'h00, "timing after reset");
  endtask : t_reset

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // tests need well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    t_regs(); t_protect(); t_retrace(); t_video(); t_width(); t_sync(); t_interleave();
    t_reset();
    conclude();
  end
endmodule : tb
